/* File: design/cpusub_pkg.sv */
// package: opcodes, field layouts and sizes for the instruction subset core
//
// Summary of operation
// (RQ1) and with memory: accumulator becomes accumulator AND addressed memory nibble, one cycle
// (RQ2) in-page jump loads 7-bit offset field, page field kept
// (RQ3) long jump: page from first word, offset from second, two cycles
// (RQ4) indirect long jump: page from instruction, offset is D[2:0] with accumulator
// (RQ5) page-two call: bump stack level, push pc, page 2 plus immediate offset
// (RQ6) long call: bump stack level, push pc, page and offset from two words
// (RQ7) indirect long call: push pc, page from instruction, offset D[2:0] with accumulator
// (RQ8) return stack holds eight levels; deeper nesting is software's fault
// (RQ9) invert accumulator: one's complement, carry flag untouched
// (RQ10) ceramic select: system clock from ceramic oscillator, ring oscillator stopped
// (RQ11) rc select: system clock from rc oscillator, ring oscillator stopped
// (RQ12) decrement y; when result is 15 the next instruction is skipped
// (RQ13) interrupt mask instruction clears the master interrupt gate
// (RQ14) masking takes effect one machine cycle after the instruction
// (RQ15) unmask sets gate; acceptance effective one machine cycle later
// (RQ16) watchdog-stop arming lets a later restart instruction stop the watchdog
// (RQ17) power-down arming validates only an immediately following power-down
// (RQ18) key read: key level to accumulator bit 0, bits 3..1 cleared
// (RQ19) port zero read: four port P0 inputs into accumulator
// (RQ20) port one read: four port P1 inputs into accumulator
// (RQ21) port two read: two P2 inputs into bits 1..0, bits 3..2 cleared
// (RQ22) power-down halts to ram backup when armed just before, else no-op
// (RQ23) skipped instruction is fetched, suppressed, and takes its normal cycle
package cpusub_pkg;
	localparam int WORD_W = 10;
	localparam int PAGE_W = 5;
	localparam int OFS_W = 7;
	localparam int NIB_W = 4;
	localparam int STACK_DEPTH = 8;
	localparam int LVL_W = 3;
	localparam int PC_W = PAGE_W + OFS_W;
	localparam int RAM_AW = 8;

	// full-word opcodes
	localparam logic [9:0] OP_AND_MEM = 10'h018;
	localparam logic [9:0] OP_INV_ACC = 10'h01C;
	localparam logic [9:0] OP_DEC_Y = 10'h017;
	localparam logic [9:0] OP_MASK_IRQS = 10'h004;
	localparam logic [9:0] OP_UNMASK_IRQS = 10'h005;
	localparam logic [9:0] OP_CERAMIC = 10'h29A;
	localparam logic [9:0] OP_RC_OSC = 10'h29B;
	localparam logic [9:0] OP_ARM_WDT_STOP = 10'h29C;
	localparam logic [9:0] OP_WDT_RESTART = 10'h2A0;
	localparam logic [9:0] OP_ARM_PDOWN = 10'h05B;
	localparam logic [9:0] OP_PDOWN = 10'h008;
	localparam logic [9:0] OP_READ_KEY = 10'h26B;
	localparam logic [9:0] OP_READ_P0 = 10'h260;
	localparam logic [9:0] OP_READ_P1 = 10'h261;
	localparam logic [9:0] OP_READ_P2 = 10'h262;
	localparam logic [9:0] OP_JMP_IND_HI = 10'h010;
	localparam logic [9:0] OP_CALL_IND_HI = 10'h030;

	// prefix-coded opcodes
	localparam logic [2:0] PFX_JMP = 3'h3;
	localparam logic [2:0] PFX_CALL2 = 3'h2;
	localparam logic [4:0] PFX_LJMP = 5'h07;
	localparam logic [4:0] PFX_LCALL = 5'h06;
	localparam logic [2:0] PFX_SECOND = 3'h4;
	localparam logic [4:0] IND_MASK_HI = 5'h10;

	localparam logic [PAGE_W-1:0] CALL_PAGE = 5'h02;
	localparam logic [NIB_W-1:0] Y_WRAP = 4'hF;
	localparam logic [NIB_W-1:0] NIB_ONE = 4'h1;
	localparam logic [PC_W-1:0] PC_ONE = 12'h001;
	localparam logic [PC_W-1:0] PC_RESET = 12'h000;
	localparam logic [LVL_W-1:0] LVL_ONE = 3'h1;
	localparam logic [LVL_W-1:0] LVL_RESET = 3'h7;

	typedef enum logic [1:0] {
		CPUSUB_FETCH = 2'b00,
		CPUSUB_SECOND = 2'b01,
		CPUSUB_HALT = 2'b10
	} cpusub_state_t;

	typedef enum logic [1:0] {
		CPUSUB_LJMP = 2'b00,
		CPUSUB_LJMP_IND = 2'b01,
		CPUSUB_LCALL = 2'b10,
		CPUSUB_LCALL_IND = 2'b11
	} cpusub_long_t;
endpackage

/* File: design/cpusub_ret_stack.sv */
// return stack memory: eight program counter slots, registered read data
`timescale 1ns/1ps
module cpusub_ret_stack #(
	parameter int DEPTH = cpusub_pkg::STACK_DEPTH,
	parameter int AW = cpusub_pkg::LVL_W,
	parameter int DW = cpusub_pkg::PC_W
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);
	import cpusub_pkg::*;

	logic [DW-1:0] mem [DEPTH];

	// deeper nesting just wraps the level and overwrites the oldest slot
	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data; // RQ8
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule

/* File: design/cpusub_in_sync.sv */
// three-stage input synchroniser; change accepted when stages two and three agree
`timescale 1ns/1ps
module cpusub_in_sync #(
	parameter int W = 1
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_out
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;
	logic [W-1:0] agree;

	assign agree = ~(s2_ff ^ s3_ff);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
			level_out <= '0;
		end else begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			level_out <= (agree & s3_ff) | (~agree & level_out);
		end
	end
endmodule

/* File: design/cpusub_core.sv */
// instruction subset execution core: decode, pc, stack, accumulator and control flags
`timescale 1ns/1ps
module cpusub_core (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [cpusub_pkg::WORD_W-1:0] instr_word,
	input wire logic [cpusub_pkg::NIB_W-1:0] mem_rdata,
	input wire logic key_pin,
	input wire logic [cpusub_pkg::NIB_W-1:0] port_zero_pin,
	input wire logic [cpusub_pkg::NIB_W-1:0] port_one_pin,
	input wire logic [1:0] port_two_pin,
	input wire logic [cpusub_pkg::NIB_W-1:0] d_reg_in,
	output logic [cpusub_pkg::PAGE_W-1:0] prog_page_field,
	output logic [cpusub_pkg::OFS_W-1:0] prog_offset_field,
	output logic [cpusub_pkg::NIB_W-1:0] acc_out,
	output logic [cpusub_pkg::NIB_W-1:0] y_index_out,
	output logic [cpusub_pkg::LVL_W-1:0] stack_level,
	output logic [cpusub_pkg::PC_W-1:0] ret_top_out,
	output logic irq_master_gate,
	output logic irq_accept_en,
	output logic ceramic_sel,
	output logic rc_sel,
	output logic ring_osc_run,
	output logic wdt_stop_armed,
	output logic wdt_stop,
	output logic ram_backup_halt,
	output logic skip_active
);
	import cpusub_pkg::*;

	//****************************************
	// state and storage
	//****************************************
	cpusub_state_t state_ff;
	cpusub_long_t long_kind_ff;
	logic [PAGE_W-1:0] long_page_ff;
	logic [NIB_W-1:0] acc_ff;
	logic [NIB_W-1:0] y_ff;
	logic [PAGE_W-1:0] page_ff;
	logic [OFS_W-1:0] ofs_ff;
	logic [LVL_W-1:0] lvl_ff;
	logic gate_ff;
	logic accept_ff;
	logic ceramic_ff;
	logic rc_ff;
	logic ring_ff;
	logic wdt_arm_ff;
	logic wdt_stop_ff;
	logic pd_arm_ff;
	logic halt_ff;
	logic skip_ff;
	logic [PC_W-1:0] ret_rdata;

	logic key_lvl;
	logic [NIB_W-1:0] p0_lvl;
	logic [NIB_W-1:0] p1_lvl;
	logic [1:0] p2_lvl;

	//****************************************
	// pin inputs
	//****************************************
	cpusub_in_sync #(.W(1)) u_sync_key (
		.clk_sys(clk_sys),
		.srst(srst),
		.pin_in(key_pin),
		.level_out(key_lvl)
	);
	cpusub_in_sync #(.W(NIB_W)) u_sync_p0 (
		.clk_sys(clk_sys),
		.srst(srst),
		.pin_in(port_zero_pin),
		.level_out(p0_lvl)
	);
	cpusub_in_sync #(.W(NIB_W)) u_sync_p1 (
		.clk_sys(clk_sys),
		.srst(srst),
		.pin_in(port_one_pin),
		.level_out(p1_lvl)
	);
	cpusub_in_sync #(.W(2)) u_sync_p2 (
		.clk_sys(clk_sys),
		.srst(srst),
		.pin_in(port_two_pin),
		.level_out(p2_lvl)
	);

	//****************************************
	// decode
	//****************************************
	wire in_fetch = (state_ff == CPUSUB_FETCH);
	wire in_second = (state_ff == CPUSUB_SECOND);
	// a skipped word still costs its fetch cycle but acts on nothing
	wire live = in_fetch && !skip_ff; // RQ23
	wire live2 = in_second && !skip_ff; // RQ23
	wire [PC_W-1:0] pc_now = {page_ff, ofs_ff};
	wire [PC_W-1:0] pc_inc = pc_now + PC_ONE;

	wire is_and = live && (instr_word == OP_AND_MEM);
	wire is_inv = live && (instr_word == OP_INV_ACC);
	wire is_dey = live && (instr_word == OP_DEC_Y);
	wire is_mask = live && (instr_word == OP_MASK_IRQS);
	wire is_unmask = live && (instr_word == OP_UNMASK_IRQS);
	wire is_ceramic = live && (instr_word == OP_CERAMIC);
	wire is_rc = live && (instr_word == OP_RC_OSC);
	wire is_wdt_arm = live && (instr_word == OP_ARM_WDT_STOP);
	wire is_wdt_rst = live && (instr_word == OP_WDT_RESTART);
	wire is_pd_arm = live && (instr_word == OP_ARM_PDOWN);
	wire is_pdown = live && (instr_word == OP_PDOWN);
	wire is_key = live && (instr_word == OP_READ_KEY);
	wire is_p0 = live && (instr_word == OP_READ_P0);
	wire is_p1 = live && (instr_word == OP_READ_P1);
	wire is_p2 = live && (instr_word == OP_READ_P2);
	wire is_jmp = live && (instr_word[9:7] == PFX_JMP);
	wire is_call2 = live && (instr_word[9:7] == PFX_CALL2);
	wire is_ljmp = live && (instr_word[9:5] == PFX_LJMP);
	wire is_lcall = live && (instr_word[9:5] == PFX_LCALL);
	wire is_ljmp_ind = live && (instr_word == OP_JMP_IND_HI);
	wire is_lcall_ind = live && (instr_word == OP_CALL_IND_HI);
	wire is_long_first = is_ljmp || is_lcall || is_ljmp_ind || is_lcall_ind;

	// indirect forms carry the page in the second word, bit 4 split off at bit 6
	wire [PAGE_W-1:0] ind_page = {instr_word[6], instr_word[3:0]};
	wire [OFS_W-1:0] ind_ofs = {d_reg_in[2:0], acc_ff};
	wire second_ok = (instr_word[9:7] == PFX_SECOND);
	wire dey_wrap = ((y_ff - NIB_ONE) == Y_WRAP); // RQ12

	cpusub_long_t nxt_long_kind;
	assign nxt_long_kind = is_ljmp ? CPUSUB_LJMP :
		is_lcall ? CPUSUB_LCALL :
		is_ljmp_ind ? CPUSUB_LJMP_IND : CPUSUB_LCALL_IND;

	wire long_is_call = live2 && (long_kind_ff == CPUSUB_LCALL || long_kind_ff == CPUSUB_LCALL_IND);
	wire long_is_ind = (long_kind_ff == CPUSUB_LJMP_IND || long_kind_ff == CPUSUB_LCALL_IND);
	wire [PAGE_W-1:0] long_page = long_is_ind ? ind_page : long_page_ff; // RQ4 RQ7
	wire [OFS_W-1:0] long_ofs = long_is_ind ? ind_ofs : instr_word[OFS_W-1:0]; // RQ3 RQ6

	// push happens with the first word of a page-two call, second word of long calls
	wire push = is_call2 || long_is_call; // RQ5 RQ6 RQ7
	wire [LVL_W-1:0] push_lvl = lvl_ff + LVL_ONE;
	// the pushed pc is the return address, one past the call
	wire [PC_W-1:0] push_pc = pc_inc;

	cpusub_ret_stack u_ret_stack (
		.clk_sys(clk_sys),
		.srst(srst),
		.wr_en(push),
		.wr_addr(push_lvl),
		.wr_data(push_pc),
		.rd_addr(lvl_ff),
		.rd_data(ret_rdata)
	);

	//****************************************
	// next values
	//****************************************
	logic [NIB_W-1:0] nxt_acc;
	assign nxt_acc = is_and ? (acc_ff & mem_rdata) : // RQ1
		is_inv ? ~acc_ff : // RQ9
		is_key ? {3'h0, key_lvl} : // RQ18
		is_p0 ? p0_lvl : // RQ19
		is_p1 ? p1_lvl : // RQ20
		is_p2 ? {2'h0, p2_lvl} : // RQ21
		acc_ff;

	logic [PC_W-1:0] nxt_pc;
	assign nxt_pc = is_jmp ? {page_ff, instr_word[OFS_W-1:0]} : // RQ2
		is_call2 ? {CALL_PAGE, instr_word[OFS_W-1:0]} : // RQ5
		(live2 && second_ok) ? {long_page, long_ofs} :
		pc_inc;

	wire pd_valid = is_pdown && pd_arm_ff; // RQ22

	cpusub_state_t nxt_state;
	assign nxt_state = pd_valid ? CPUSUB_HALT :
		(in_fetch && (is_long_first || (skip_ff && (instr_word[9:5] == PFX_LJMP ||
			instr_word[9:5] == PFX_LCALL || instr_word == OP_JMP_IND_HI ||
			instr_word == OP_CALL_IND_HI)))) ? CPUSUB_SECOND :
		in_second ? CPUSUB_FETCH : state_ff;

	// skip covers both words of a skipped two-word instruction
	wire nxt_skip = is_dey ? dey_wrap : (in_fetch && nxt_state == CPUSUB_SECOND) ? skip_ff : 1'b0; // RQ12 RQ23

	//****************************************
	// registers
	//****************************************
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_ff <= CPUSUB_FETCH;
			long_kind_ff <= CPUSUB_LJMP;
			long_page_ff <= '0;
			acc_ff <= '0;
			y_ff <= '0;
			{page_ff, ofs_ff} <= PC_RESET;
			lvl_ff <= LVL_RESET;
			skip_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			skip_ff <= nxt_skip;
			acc_ff <= nxt_acc;
			if (is_long_first) begin
				long_kind_ff <= nxt_long_kind;
				long_page_ff <= instr_word[PAGE_W-1:0]; // RQ3 RQ6
			end
			if (is_dey) begin
				y_ff <= y_ff - NIB_ONE; // RQ12
			end
			if (state_ff != CPUSUB_HALT) begin
				{page_ff, ofs_ff} <= nxt_pc;
			end
			if (push) begin
				lvl_ff <= push_lvl; // RQ8
			end
		end
	end

	// gate moves at once; acceptance follows one machine cycle later
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			gate_ff <= 1'b0;
			accept_ff <= 1'b0;
		end else begin
			if (is_mask) begin
				gate_ff <= 1'b0; // RQ13
			end else if (is_unmask) begin
				gate_ff <= 1'b1; // RQ15
			end
			accept_ff <= gate_ff; // RQ14 RQ15
		end
	end

	// ring oscillator runs until a source is chosen
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ceramic_ff <= 1'b0;
			rc_ff <= 1'b0;
			ring_ff <= 1'b1;
		end else if (is_ceramic) begin
			ceramic_ff <= 1'b1; // RQ10
			rc_ff <= 1'b0;
			ring_ff <= 1'b0;
		end else if (is_rc) begin
			rc_ff <= 1'b1; // RQ11
			ceramic_ff <= 1'b0;
			ring_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wdt_arm_ff <= 1'b0;
			wdt_stop_ff <= 1'b0;
			pd_arm_ff <= 1'b0;
			halt_ff <= 1'b0;
		end else begin
			if (is_wdt_arm) begin
				wdt_arm_ff <= 1'b1; // RQ16
			end
			if (is_wdt_rst && wdt_arm_ff) begin
				wdt_stop_ff <= 1'b1; // RQ16
			end
			// arming lasts exactly one instruction slot
			if (in_fetch) begin
				pd_arm_ff <= is_pd_arm; // RQ17
			end
			if (pd_valid) begin
				halt_ff <= 1'b1; // RQ22
			end
		end
	end

	//****************************************
	// outputs
	//****************************************
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			prog_page_field <= '0;
			prog_offset_field <= '0;
			acc_out <= '0;
			y_index_out <= '0;
			stack_level <= LVL_RESET;
			ret_top_out <= '0;
			irq_master_gate <= 1'b0;
			irq_accept_en <= 1'b0;
			ceramic_sel <= 1'b0;
			rc_sel <= 1'b0;
			ring_osc_run <= 1'b1;
			wdt_stop_armed <= 1'b0;
			wdt_stop <= 1'b0;
			ram_backup_halt <= 1'b0;
			skip_active <= 1'b0;
		end else begin
			prog_page_field <= page_ff;
			prog_offset_field <= ofs_ff;
			acc_out <= acc_ff;
			y_index_out <= y_ff;
			stack_level <= lvl_ff;
			ret_top_out <= ret_rdata;
			irq_master_gate <= gate_ff;
			irq_accept_en <= accept_ff;
			ceramic_sel <= ceramic_ff;
			rc_sel <= rc_ff;
			ring_osc_run <= ring_ff;
			wdt_stop_armed <= wdt_arm_ff;
			wdt_stop <= wdt_stop_ff;
			ram_backup_halt <= halt_ff;
			skip_active <= skip_ff;
		end
	end
endmodule

/* File: verification/cpusub_core_monitor.sv */
// checker: timing relations between the instruction stream and the core outputs
`timescale 1ns/1ps
module cpusub_core_monitor (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [cpusub_pkg::WORD_W-1:0] instr_word,
	input wire logic [cpusub_pkg::NIB_W-1:0] mem_rdata,
	input wire logic [cpusub_pkg::PAGE_W-1:0] prog_page_field,
	input wire logic [cpusub_pkg::OFS_W-1:0] prog_offset_field,
	input wire logic [cpusub_pkg::NIB_W-1:0] acc_out,
	input wire logic [cpusub_pkg::NIB_W-1:0] y_index_out,
	input wire logic [cpusub_pkg::LVL_W-1:0] stack_level,
	input wire logic irq_master_gate,
	input wire logic irq_accept_en,
	input wire logic ceramic_sel,
	input wire logic rc_sel,
	input wire logic ring_osc_run,
	input wire logic ram_backup_halt,
	input wire logic skip_active
);
	import cpusub_pkg::*;
	// ********************************
	// qualifier: previous word cannot skip, halt or pair with this one
	// ********************************
	logic plain_ff;
	logic arm_ff;
	wire logic plain_now = instr_word inside {OP_AND_MEM, OP_INV_ACC, OP_READ_KEY, OP_READ_P0, OP_READ_P1,
		OP_READ_P2, OP_CERAMIC, OP_RC_OSC};
	wire logic [6:0] ofs_now = instr_word[6:0];
	wire logic cer_now = instr_word == OP_CERAMIC;
	always_ff @(posedge clk_sys) begin
		arm_ff <= !srst && instr_word == OP_ARM_PDOWN;
		plain_ff <= !srst && (plain_now || (instr_word == OP_PDOWN && !arm_ff));
	end
	wire logic go = plain_ff && !ram_backup_halt && !srst;
	default clocking mon_cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);
	// ********************************
	// properties; outputs trail the executing edge by one cycle
	// ********************************
	and_mem_a: assert property (go && instr_word == OP_AND_MEM |=> ##1 acc_out == ($past(acc_out) & $past(mem_rdata, 2)))
		else $error("and with memory gave a wrong accumulator");
	inv_acc_a: assert property (go && instr_word == OP_INV_ACC |=> ##1 acc_out == ~$past(acc_out))
		else $error("invert gave a wrong accumulator");
	jump_in_page_a: assert property (go && instr_word[9:7] == PFX_JMP |=> ##1
		prog_offset_field == $past(ofs_now, 2) && prog_page_field == $past(prog_page_field))
		else $error("in-page jump target wrong");
	call_two_a: assert property (go && instr_word[9:7] == PFX_CALL2 |=> ##1 prog_page_field == CALL_PAGE &&
		prog_offset_field == $past(ofs_now, 2) && stack_level == $past(stack_level) + LVL_ONE)
		else $error("page two call target or level wrong");
	key_clear_a: assert property (go && instr_word == OP_READ_KEY |=> ##1 acc_out[3:1] == 3'h0)
		else $error("key read left upper bits set");
	port_two_a: assert property (go && instr_word == OP_READ_P2 |=> ##1 acc_out[3:2] == 2'h0)
		else $error("port two read left upper bits set");
	dec_y_a: assert property (go && instr_word == OP_DEC_Y |=> ##1 y_index_out == $past(y_index_out) - NIB_ONE)
		else $error("y decrement wrong");
	dey_skip_a: assert property (go && instr_word == OP_DEC_Y |=> ##1 skip_active == (y_index_out == Y_WRAP))
		else $error("skip flag after y decrement wrong");
	mask_delay_a: assert property (go && instr_word == OP_MASK_IRQS && irq_master_gate && irq_accept_en |=>
		##1 (!irq_master_gate && irq_accept_en) ##1 !irq_accept_en)
		else $error("mask timing wrong");
	unmask_delay_a: assert property (go && instr_word == OP_UNMASK_IRQS && !irq_master_gate && !irq_accept_en |=>
		##1 (irq_master_gate && !irq_accept_en) ##1 irq_accept_en)
		else $error("unmask timing wrong");
	osc_pick_a: assert property (go && (cer_now || instr_word == OP_RC_OSC) |=> ##1
		!ring_osc_run && ($past(cer_now, 2) ? ceramic_sel : rc_sel))
		else $error("clock source selection wrong");
	halt_freeze_a: assert property (ram_backup_halt |=> ram_backup_halt && $stable(prog_offset_field) &&
		$stable(prog_page_field) && $stable(acc_out))
		else $error("halted core still changing");
	pdown_refuse_a: assert property (go && instr_word == OP_PDOWN |=> ##1 !ram_backup_halt)
		else $error("unarmed power-down halted");
	cover property (go && instr_word == OP_DEC_Y && y_index_out == 4'h0);
	cover property (go && instr_word == OP_MASK_IRQS && irq_master_gate && irq_accept_en);
	cover property (ram_backup_halt);
endmodule

bind cpusub_core cpusub_core_monitor u_mon (.*);

/* File: verification/tb.sv */
// self-checking bench for the instruction subset core
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
	$display("Error at %0t: got %0h expected %0h", $time, got, exp); end end
module tb;
	import cpusub_pkg::*;
	// ********************************
	// stimulus and dut
	// ********************************
	localparam logic [9:0] IDLE = OP_PDOWN;
	localparam int WATCH_NS = 8 * 2500;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [9:0] instr_word = IDLE;
	logic [3:0] mem_rdata = 4'h0, port_zero_pin = 4'h0, port_one_pin = 4'h0, d_reg_in = 4'h0;
	logic key_pin = 1'b0;
	logic [1:0] port_two_pin = 2'h0;
	logic [4:0] prog_page_field, p;
	logic [6:0] prog_offset_field, a;
	logic [3:0] acc_out, y_index_out, acc;
	logic [2:0] stack_level, lvl;
	logic [11:0] ret_top_out, tgt, ret;
	logic irq_master_gate, irq_accept_en, ceramic_sel, rc_sel, ring_osc_run, wdt_stop_armed, wdt_stop;
	logic ram_backup_halt;
	int err_total = 0;
	int samples_checked = 0;
	always #4 clk_sys = ~clk_sys;
	cpusub_core u_dut (.clk_sys(clk_sys), .srst(srst), .instr_word(instr_word), .mem_rdata(mem_rdata),
		.key_pin(key_pin), .port_zero_pin(port_zero_pin), .port_one_pin(port_one_pin),
		.port_two_pin(port_two_pin), .d_reg_in(d_reg_in), .prog_page_field(prog_page_field),
		.prog_offset_field(prog_offset_field), .acc_out(acc_out), .y_index_out(y_index_out),
		.stack_level(stack_level), .ret_top_out(ret_top_out), .irq_master_gate(irq_master_gate),
		.irq_accept_en(irq_accept_en), .ceramic_sel(ceramic_sel), .rc_sel(rc_sel),
		.ring_osc_run(ring_osc_run), .wdt_stop_armed(wdt_stop_armed), .wdt_stop(wdt_stop),
		.ram_backup_halt(ram_backup_halt), .skip_active());
	function automatic logic [9:0] page_word(input logic [4:0] pg);
		return {PFX_SECOND, pg[4], 2'b00, pg[3:0]};
	endfunction
	// two words back to back, then sample once the second word's effect is visible
	task automatic run(input logic [9:0] w1, input logic [9:0] w2);
		@(posedge clk_sys) instr_word <= w1;
		@(posedge clk_sys) instr_word <= w2;
		@(posedge clk_sys) instr_word <= IDLE;
		@(posedge clk_sys);
		#1;
	endtask
	task automatic conclude();
		$display("checks %0d, errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ********************************
	// sequence
	// ********************************
	initial begin
		void'($urandom(32'h03995db1));
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		#1;
		`CHK({stack_level, ring_osc_run}, {3'h7, 1'b1})
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_sys) {port_zero_pin, port_one_pin, port_two_pin, key_pin, mem_rdata, d_reg_in} <= 19'($urandom);
			// pins pass a synchroniser, so let them settle before reading
			repeat (6) @(posedge clk_sys);
			run(OP_READ_P0, IDLE);
			`CHK(acc_out, port_zero_pin)
			run(OP_READ_P1, IDLE);
			`CHK(acc_out, port_one_pin)
			run(OP_READ_P2, IDLE);
			`CHK(acc_out, {2'h0, port_two_pin})
			run(OP_READ_KEY, OP_INV_ACC);
			acc = ~{3'h0, key_pin};
			`CHK(acc_out, acc)
			run(OP_AND_MEM, IDLE);
			acc = acc & mem_rdata;
			`CHK(acc_out, acc)
			p = 5'($urandom);
			a = {1'b0, 6'($urandom)};
			run({PFX_LJMP, p}, {PFX_SECOND, a});
			`CHK({prog_page_field, prog_offset_field}, {p, a})
			run(IDLE, {PFX_JMP, ~a});
			`CHK({prog_page_field, prog_offset_field}, {p, ~a})
			run(OP_JMP_IND_HI, page_word(p));
			`CHK({prog_page_field, prog_offset_field}, {p, d_reg_in[2:0], acc})
		end
		lvl = 3'h7;
		// pushed value is the pushing word's pc plus one (w2 of each run); idle words advance pc between runs
		tgt = {p, d_reg_in[2:0], acc} - 12'h001;
		// exactly eight nested calls: deeper nesting is not defined
		for (int i = 0; i < 8; i++) begin
			p = 5'($urandom);
			a = {1'b0, 6'($urandom)};
			lvl = lvl + 3'h1;
			case (i % 3)
				0: begin
					run(IDLE, {PFX_CALL2, a});
					p = CALL_PAGE;
				end
				1: run({PFX_LCALL, p}, {PFX_SECOND, a});
				default: begin
					run(OP_CALL_IND_HI, page_word(p));
					a = {d_reg_in[2:0], acc};
				end
			endcase
			`CHK({stack_level, prog_page_field, prog_offset_field}, {lvl, p, a})
			ret = tgt + 12'h005;
			tgt = {p, a};
			// stack read data trails the push by one more register
			@(posedge clk_sys);
			#1;
			`CHK(ret_top_out, ret)
		end
		run(OP_DEC_Y, OP_INV_ACC);
		`CHK({y_index_out, acc_out}, {4'hF, acc})
		run(OP_DEC_Y, OP_INV_ACC);
		acc = ~acc;
		`CHK({y_index_out, acc_out}, {4'hE, acc})
		run(OP_UNMASK_IRQS, OP_MASK_IRQS);
		`CHK({irq_master_gate, irq_accept_en}, 2'b01)
		run(OP_MASK_IRQS, OP_UNMASK_IRQS);
		`CHK({irq_master_gate, irq_accept_en}, 2'b10)
		run(OP_MASK_IRQS, IDLE);
		`CHK({irq_master_gate, irq_accept_en}, 2'b00)
		run(OP_UNMASK_IRQS, IDLE);
		`CHK({irq_master_gate, irq_accept_en}, 2'b11)
		run(IDLE, OP_CERAMIC);
		`CHK({ceramic_sel, ring_osc_run}, 2'b10)
		run(IDLE, OP_RC_OSC);
		`CHK({rc_sel, ring_osc_run}, 2'b10)
		run(OP_WDT_RESTART, IDLE);
		`CHK({wdt_stop_armed, wdt_stop}, 2'b00)
		run(OP_ARM_WDT_STOP, OP_WDT_RESTART);
		`CHK({wdt_stop_armed, wdt_stop}, 2'b11)
		run(OP_ARM_PDOWN, OP_INV_ACC);
		acc = ~acc;
		`CHK({ram_backup_halt, acc_out}, {1'b0, acc})
		run(OP_ARM_PDOWN, OP_PDOWN);
		`CHK(ram_backup_halt, 1'b1)
		run(OP_INV_ACC, OP_READ_P0);
		`CHK({ram_backup_halt, acc_out}, {1'b1, acc})
		@(posedge clk_sys) srst <= 1'b1;
		repeat (6) @(posedge clk_sys);
		srst <= 1'b0;
		#1;
		`CHK({ram_backup_halt, stack_level, ring_osc_run}, {1'b0, 3'h7, 1'b1})
		conclude();
	end
	initial begin
		#WATCH_NS;
		err_total++;
		conclude();
	end
endmodule
